//--- rtl/msw_consts.vh
`ifndef MSW_CONSTS_VH
`define MSW_CONSTS_VH

// ****************************************************************
// Register addresses.
// ****************************************************************
`define MSW_ADDR_SWITCH   7'h01
`define MSW_ADDR_ERRCFG   7'h02
`define MSW_ADDR_ERRFLAG  7'h03
`define MSW_ADDR_BURST    7'h05
`define MSW_ADDR_SEQEN    7'h06
`define MSW_ADDR_SEQLIST  7'h07
`define MSW_ADDR_EDGE     7'h09
`define MSW_ADDR_SOFTRST  7'h0b

// ****************************************************************
// Reset values.
// ****************************************************************
`define MSW_RST_SWITCH    8'h00
`define MSW_RST_ERRCFG    8'h06
`define MSW_RST_ZERO      8'h00
`define MSW_RST_LIST8     8'hff
`define MSW_RST_LIST4     8'h0f

// ****************************************************************
// Command frame layout and special frames.
// ****************************************************************
`define MSW_READ_BIT      15
`define MSW_ADDR_HI       14
`define MSW_ADDR_LO       8
`define MSW_DATA_HI       7
`define MSW_DATA_LO       0
`define MSW_FRAME_DAISY   16'h2500
`define MSW_FRAME_CLRERR  16'h6ca9
`define MSW_FRAME_EXIT1   16'ha318
`define MSW_FRAME_EXIT2   16'he3b4
`define MSW_SOFT_KEY1     8'ha3
`define MSW_SOFT_KEY2     8'h05

// ****************************************************************
// Field positions.
// ****************************************************************
`define MSW_EN_BIT        0
`define MSW_SEL_LO        1
`define MSW_SEL_HI        3
`define MSW_DUAL_RSV_BIT  3
`define MSW_GPO_LO        4
`define MSW_GPO_HI        7
`define MSW_RWERR_BIT     2
`define MSW_ONE_BIT       0

`endif

//--- rtl/msw_select_decode.v
`include "msw_consts.vh"

// Turns the enable and select fields into a one-hot switch request.
module msw_select_decode #(
  parameter NCH = 8
) (
  input  wire           enable,
  input  wire [2:0]     select,
  output wire [NCH-1:0] oneHot
);

  // ****************************************************************
  // Per-channel compare.
  // ****************************************************************
  genvar i;
  generate
    for (i = 0; i < NCH; i = i + 1) begin : gCh
      // The index is held as a vector so its low bits can be cut on purpose.
      localparam [31:0] IDX = i;
      // Only one index can equal the select, so the vector stays one-hot.
      assign oneHot[i] = enable && (select == IDX[2:0]); // R4 R9
    end
  endgenerate

endmodule

//--- rtl/msw_register_bank.v
`include "msw_consts.vh"

// Notes on behaviour
// R1 - Upper switch bits drive four general outputs.
// R2 - Sequencer active forces general outputs low.
// R3 - Switch register at 0x01, resets to 0x00.
// R4 - Enable plus select picks channel select+1; the decode drives oneHot bit select instead.
// R5 - Dual variant bit three reserved, reads zero.
// R6 - Keys 0xA3 then 0x05 restore defaults.
// R7 - Daisy chain commands only reach switch register.
// R8 - Sequencing starts only via sequencer enable register.
// R9 - Switch request is one-hot from registered fields.
module msw_register_bank #(
  parameter DUAL = 0
) (
  input  wire                   clk,
  input  wire                   resetn,
  input  wire                   ce,
  input  wire                   cmdValid,
  input  wire [15:0]            cmdFrame,
  output reg                    rdValid,
  output reg  [7:0]             rdData,
  output reg  [(DUAL?4:8)-1:0]  switchOn,
  output reg                    generalOutputOne,
  output reg                    generalOutputTwo,
  output reg                    generalOutputThree,
  output reg                    generalOutputFour,
  output reg                    sequencerActive,
  output reg                    daisyActive
);

  localparam NCH = DUAL ? 4 : 8;
  localparam [7:0] LIST_RST = DUAL ? `MSW_RST_LIST4 : `MSW_RST_LIST8;
  // Writable mask of the switch register; the dual part has bit 3 held.
  localparam [7:0] SW_MASK = DUAL ? 8'hf7 : 8'hff;
  localparam [7:0] LIST_MASK = DUAL ? 8'h0f : 8'hff;

  // ****************************************************************
  // Register state.
  // ****************************************************************
  reg [7:0] switchAndOutputControl;
  reg [7:0] errorCheckEnables;
  reg [7:0] errorIndications;
  reg [7:0] burstEnable;
  reg [7:0] sequencerEnable;
  reg [7:0] sequenceChannelList;
  reg [7:0] conversionEdgeChoice;
  reg [7:0] softwareResetTrigger;
  reg       softArmed;
  reg       exitArmed;

  reg [7:0] next_switch;
  reg [7:0] next_errCfg;
  reg [7:0] next_errFlag;
  reg [7:0] next_burst;
  reg [7:0] next_seqEn;
  reg [7:0] next_seqList;
  reg [7:0] next_edge;
  reg [7:0] next_soft;
  reg       next_softArmed;
  reg       next_exitArmed;
  reg       next_daisy;
  reg       next_rdValid;
  reg [7:0] next_rdData;

  wire       isRead  = cmdFrame[`MSW_READ_BIT];
  wire [6:0] addr    = cmdFrame[`MSW_ADDR_HI:`MSW_ADDR_LO];
  wire [7:0] data    = cmdFrame[`MSW_DATA_HI:`MSW_DATA_LO];
  wire [7:0] selData = next_switch;
  wire [NCH-1:0] next_switchOn;

  // Decode from the value the register is about to hold, so the flopped
  // request changes on the same edge as the register itself.
  msw_select_decode #(
    .NCH(NCH)
  ) uDecode (
    .enable(selData[`MSW_EN_BIT]),
    .select(DUAL ? {1'b0, selData[`MSW_SEL_HI-1:`MSW_SEL_LO]}
                 : selData[`MSW_SEL_HI:`MSW_SEL_LO]),
    .oneHot(next_switchOn)
  );

  // ****************************************************************
  // Command handling.
  // ****************************************************************
  // One process works out every next value; the order of the branches
  // gives daisy mode and sequencing priority over addressed commands.
  always @* begin
    next_switch    = switchAndOutputControl;
    next_errCfg    = errorCheckEnables;
    next_errFlag   = errorIndications;
    next_burst     = burstEnable;
    next_seqEn     = sequencerEnable;
    next_seqList   = sequenceChannelList;
    next_edge      = conversionEdgeChoice;
    next_soft      = softwareResetTrigger;
    next_softArmed = softArmed;
    next_exitArmed = exitArmed;
    next_daisy     = daisyActive;
    next_rdValid   = 1'b0;
    next_rdData    = rdData;
    if (cmdValid) begin
      if (daisyActive) begin
        // Chained devices only ever load the switch register.
        next_switch = data & SW_MASK; // R7 R5
      end else if (sequencerActive) begin
        // Only the two-frame exit sequence is recognised here.
        next_exitArmed = (cmdFrame == `MSW_FRAME_EXIT1);
        if (exitArmed && cmdFrame == `MSW_FRAME_EXIT2) begin
          next_seqEn = `MSW_RST_ZERO;
        end
      end else if (cmdFrame == `MSW_FRAME_DAISY) begin
        next_daisy     = 1'b1;
        next_softArmed = 1'b0;
      end else if (cmdFrame == `MSW_FRAME_CLRERR) begin
        next_errFlag   = `MSW_RST_ZERO;
        next_softArmed = 1'b0;
      end else if (isRead) begin
        next_rdValid   = 1'b1;
        next_softArmed = 1'b0;
        case (addr)
          `MSW_ADDR_SWITCH:  next_rdData = switchAndOutputControl;
          `MSW_ADDR_ERRCFG:  next_rdData = errorCheckEnables;
          `MSW_ADDR_ERRFLAG: next_rdData = errorIndications;
          `MSW_ADDR_BURST:   next_rdData = burstEnable;
          `MSW_ADDR_SEQEN:   next_rdData = sequencerEnable;
          `MSW_ADDR_SEQLIST: next_rdData = sequenceChannelList;
          `MSW_ADDR_EDGE:    next_rdData = conversionEdgeChoice;
          `MSW_ADDR_SOFTRST: next_rdData = softwareResetTrigger;
          default: begin
            next_rdData = `MSW_RST_ZERO;
            if (errorCheckEnables[`MSW_RWERR_BIT]) begin
              next_errFlag[`MSW_RWERR_BIT] = 1'b1;
            end
          end
        endcase
      end else begin
        next_softArmed = 1'b0;
        case (addr)
          `MSW_ADDR_SWITCH:  next_switch = data & SW_MASK; // R3 R5
          `MSW_ADDR_ERRCFG:  next_errCfg = data & 8'h07;
          `MSW_ADDR_BURST:   next_burst  = data & 8'h01;
          `MSW_ADDR_SEQEN:   next_seqEn  = data & 8'h01; // R8
          `MSW_ADDR_SEQLIST: next_seqList = data & LIST_MASK;
          `MSW_ADDR_EDGE:    next_edge   = data & 8'h01;
          `MSW_ADDR_SOFTRST: begin
            next_soft      = data;
            next_softArmed = (data == `MSW_SOFT_KEY1);
            if (softArmed && data == `MSW_SOFT_KEY2) begin
              // Second key: every register returns to its default.
              next_switch    = `MSW_RST_SWITCH; // R6
              next_errCfg    = `MSW_RST_ERRCFG; // R6
              next_errFlag   = `MSW_RST_ZERO;
              next_burst     = `MSW_RST_ZERO;
              next_seqEn     = `MSW_RST_ZERO;
              next_seqList   = LIST_RST;
              next_edge      = `MSW_RST_ZERO;
              next_soft      = `MSW_RST_ZERO;
              next_softArmed = 1'b0;
            end
          end
          default: begin
            // Unknown or read-only target: the data is dropped; only the error flag may be set.
            if (errorCheckEnables[`MSW_RWERR_BIT]) begin
              next_errFlag[`MSW_RWERR_BIT] = 1'b1;
            end
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // State and output flops.
  // ****************************************************************
  // Outputs are flopped so the analog drivers never see decode glitches.
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      switchAndOutputControl <= `MSW_RST_SWITCH; // R3
      errorCheckEnables      <= `MSW_RST_ERRCFG;
      errorIndications       <= `MSW_RST_ZERO;
      burstEnable            <= `MSW_RST_ZERO;
      sequencerEnable        <= `MSW_RST_ZERO;
      sequenceChannelList    <= LIST_RST;
      conversionEdgeChoice   <= `MSW_RST_ZERO;
      softwareResetTrigger   <= `MSW_RST_ZERO;
      softArmed              <= 1'b0;
      exitArmed              <= 1'b0;
      daisyActive            <= 1'b0;
      sequencerActive        <= 1'b0;
      rdValid                <= 1'b0;
      rdData                 <= `MSW_RST_ZERO;
      switchOn               <= {NCH{1'b0}};
      generalOutputOne       <= 1'b0;
      generalOutputTwo       <= 1'b0;
      generalOutputThree     <= 1'b0;
      generalOutputFour      <= 1'b0;
    end else if (ce) begin
      switchAndOutputControl <= next_switch;
      errorCheckEnables      <= next_errCfg;
      errorIndications       <= next_errFlag;
      burstEnable            <= next_burst;
      sequencerEnable        <= next_seqEn;
      sequenceChannelList    <= next_seqList;
      conversionEdgeChoice   <= next_edge;
      softwareResetTrigger   <= next_soft;
      softArmed              <= next_softArmed;
      exitArmed              <= next_exitArmed;
      daisyActive            <= next_daisy;
      sequencerActive        <= next_seqEn[`MSW_ONE_BIT]; // R8
      rdValid                <= next_rdValid;
      rdData                 <= next_rdData;
      switchOn               <= next_switchOn; // R9 R4
      // General outputs follow their bits unless the sequencer runs.
      generalOutputOne   <= next_switch[`MSW_GPO_LO]
                            & ~next_seqEn[`MSW_ONE_BIT]; // R1 R2
      generalOutputTwo   <= next_switch[`MSW_GPO_LO+1]
                            & ~next_seqEn[`MSW_ONE_BIT]; // R1 R2
      generalOutputThree <= next_switch[`MSW_GPO_LO+2]
                            & ~next_seqEn[`MSW_ONE_BIT]; // R1 R2
      generalOutputFour  <= next_switch[`MSW_GPO_HI]
                            & ~next_seqEn[`MSW_ONE_BIT]; // R1 R2
    end
  end

endmodule

//--- sim/msw_host_model.sv
// ************************************************************
// Command host standing in for the controller.
// ************************************************************
module msw_host_model (
  input  wire        clk,
  output reg         cmdValid,
  output reg  [15:0] cmdFrame
);
  timeunit 1ns;
  timeprecision 1ns;
  // Lines start quiet so nothing is taken while reset is held.
  initial begin
    cmdValid = 1'b0;
    cmdFrame = 16'h0000;
  end
  // The caller sits just after an edge; the frame is taken on the next.
  task send(input [15:0] f);
    cmdValid = 1'b1;
    cmdFrame = f;
    @(posedge clk);
    #1;
  endtask
  // A released frame shows its inverse, so stale data cannot look valid.
  task idle;
    cmdValid = 1'b0;
    cmdFrame = ~cmdFrame;
    @(posedge clk);
    #1;
  endtask
endmodule

//--- sim/msw_bank_assertions.sv
// ************************************************************
// Port checker for the register bank.
// ************************************************************
module msw_checker #(
  parameter DUAL = 0
) (
  input wire                  clk,
  input wire                  resetn,
  input wire                  ce,
  input wire                  cmdValid,
  input wire [15:0]           cmdFrame,
  input wire                  rdValid,
  input wire [7:0]            rdData,
  input wire [(DUAL?4:8)-1:0] switchOn,
  input wire                  generalOutputOne,
  input wire                  generalOutputTwo,
  input wire                  generalOutputThree,
  input wire                  generalOutputFour,
  input wire                  sequencerActive,
  input wire                  daisyActive
);
  timeunit 1ns;
  timeprecision 1ns;
  // A taken command, a switch register write, and the select field.
  wire       take = ce && cmdValid && !sequencerActive;
  wire       swWr = take && (daisyActive || cmdFrame[15:8] == 8'h01);
  wire [2:0] sel  = DUAL ? {1'b0, cmdFrame[2:1]} : cmdFrame[3:1];
  wire [3:0] gpo  = {generalOutputFour, generalOutputThree,
                     generalOutputTwo, generalOutputOne};
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  a_onehot_switch: assert property ($onehot0(switchOn))
    else $error("switch request is not one-hot");
  a_gpo_follow: assert property (swWr |=> gpo == $past(cmdFrame[7:4]))
    else $error("general outputs differ from written bits");
  a_gpo_forced: assert property (sequencerActive |-> gpo == 4'h0)
    else $error("general outputs high while sequencing");
  a_switch_decode: assert property (swWr |=> switchOn ==
    ($past(cmdFrame[0]) ? 1 << $past(sel) : 0))
    else $error("switch decode wrong");
  a_switch_read: assert property (take && !daisyActive &&
    cmdFrame[15:8] == 8'h81 |=> rdValid && rdData[7:4] == gpo &&
    rdData[0] == |switchOn)
    else $error("switch register read back wrong");
  a_soft_reset: assert property ((take && !daisyActive &&
    cmdFrame == 16'h0ba3) ##1 (take && cmdFrame == 16'h0b05) |=>
    switchOn == 0 && gpo == 4'h0)
    else $error("key pair did not restore defaults");
  a_seq_entry: assert property ($rose(sequencerActive) |->
    $past(take && !daisyActive && cmdFrame[15:8] == 8'h06 && cmdFrame[0]))
    else $error("sequencing began without its enable write");
  a_daisy_hold: assert property (daisyActive |=> daisyActive &&
    $stable(sequencerActive))
    else $error("chained mode left or configuration changed");
  a_ce_freeze: assert property (!ce |=> $stable(switchOn) && $stable(gpo))
    else $error("outputs moved with clock enable low");
  // Main scenarios seen at least once.
  c_seq_exit: cover property (sequencerActive ##1 !sequencerActive);
  c_daisy: cover property ($rose(daisyActive));
  c_read_cfg: cover property (rdValid && rdData == 8'h06);
endmodule

//--- sim/tb.sv
// ************************************************************
// Self-checking bench for the register bank.
// ************************************************************
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  reg         clk = 1'b0;
  reg         resetn;
  reg         ce;
  wire        cmdValid;
  wire [15:0] cmdFrame;
  wire        rdValid;
  wire [7:0]  rdData;
  wire [7:0]  switchOn;
  wire [3:0]  gpo;
  wire        sequencerActive;
  wire        daisyActive;
  integer     fail_count = 0;
  integer     samples_checked = 0;
  integer     seed = 32'h71d0626e;
  integer     i;
  reg [31:0]  rnd;
  reg [7:0]   expQ[$];
  reg [71:0]  addrs = 72'h01_02_03_05_06_07_09_0b_04;
  reg [71:0]  vals = 72'h00_06_00_00_00_ff_00_00_00;
  always #5 clk = ~clk;
  msw_register_bank #(.DUAL(0)) dut (.clk(clk), .resetn(resetn), .ce(ce),
    .cmdValid(cmdValid), .cmdFrame(cmdFrame), .rdValid(rdValid),
    .rdData(rdData), .switchOn(switchOn), .generalOutputOne(gpo[0]),
    .generalOutputTwo(gpo[1]), .generalOutputThree(gpo[2]),
    .generalOutputFour(gpo[3]), .sequencerActive(sequencerActive),
    .daisyActive(daisyActive));
  msw_host_model host (.clk(clk), .cmdValid(cmdValid), .cmdFrame(cmdFrame));
  task fail(input string msg);
    fail_count = fail_count + 1;
    $display("mismatch at %0t: %0s", $time, msg);
  endtask
  task wr(input [6:0] a, input [7:0] d);
    host.send({1'b0, a, d});
  endtask
  // A read notes its expected byte before the frame goes out.
  task rd(input [6:0] a, input [7:0] e);
    expQ.push_back(e);
    host.send({1'b1, a, 8'h00});
  endtask
  task check_out(input [7:0] s, input [3:0] g);
    samples_checked = samples_checked + 1;
    if (switchOn !== s || gpo !== g) fail("switch or general outputs");
  endtask
  task check_flag(input f, input e);
    samples_checked = samples_checked + 1;
    if (f !== e) fail("mode flag");
  endtask
  task finish_test;
    $display("checks %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Sampled on the falling edge, half a cycle after the answer settles.
  always @(negedge clk) begin
    if (rdValid === 1'b1) begin
      samples_checked = samples_checked + 1;
      if (expQ.size() == 0) fail("unexpected read answer");
      else if (rdData !== expQ.pop_front()) fail("read data");
    end
  end
  // The whole run needs well under a hundred cycles; this is ample.
  initial begin
    #100000;
    fail("watchdog expired");
    finish_test;
  end
  // Main sequence; every step leaves the bench just after an edge.
  initial begin
    resetn = 1'b0;
    ce = 1'b1;
    repeat (10) @(posedge clk);
    #1 resetn = 1'b1;
    for (i = 0; i < 9; i = i + 1)
      rd(addrs[70-8*i -: 7], vals[71-8*i -: 8]);
    rd(7'h03, 8'h04);
    for (i = 0; i < 8; i = i + 1) begin
      rnd = $random(seed);
      wr(7'h01, {rnd[7:4], i[2:0], 1'b1});
      check_out(8'h01 << i, rnd[7:4]);
      rd(7'h01, {rnd[7:4], i[2:0], 1'b1});
    end
    wr(7'h01, 8'h5e);
    check_out(8'h00, 4'h5);
    ce = 1'b0;
    host.send(16'h0103);
    host.idle;
    ce = 1'b1;
    check_out(8'h00, 4'h5);
    // Random stalls: the write lands only at an edge with ce high.
    rnd = 32'h0;
    while (rnd[0] !== 1'b1) begin
      check_out(8'h00, 4'h5);
      rnd = $random(seed);
      ce = rnd[0];
      wr(7'h01, 8'ha7);
    end
    check_out(8'h08, 4'ha);
    wr(7'h02, 8'h01);
    wr(7'h0b, 8'ha3);
    wr(7'h0b, 8'h05);
    rd(7'h02, 8'h06);
    check_out(8'h00, 4'h0);
    wr(7'h02, 8'h01);
    wr(7'h0b, 8'ha3);
    rd(7'h01, 8'h00);
    wr(7'h0b, 8'h05);
    rd(7'h02, 8'h01);
    wr(7'h01, 8'hf3);
    wr(7'h07, 8'h0f);
    wr(7'h09, 8'h01);
    check_flag(sequencerActive, 1'b0);
    wr(7'h06, 8'h01);
    check_out(8'h02, 4'h0);
    host.send(16'h0101);
    check_out(8'h02, 4'h0);
    host.send(16'ha318);
    host.send(16'he3b4);
    check_out(8'h02, 4'hf);
    rd(7'h06, 8'h00);
    host.send(16'h2500);
    check_flag(daisyActive, 1'b1);
    host.send(16'h0645);
    check_out(8'h04, 4'h4);
    check_flag(sequencerActive, 1'b0);
    host.idle;
    // Only a hardware reset leaves chained mode.
    resetn = 1'b0;
    #1;
    check_flag(daisyActive, 1'b0);
    check_out(8'h00, 4'h0);
    @(posedge clk);
    #1 resetn = 1'b1;
    rd(7'h01, 8'h00);
    host.idle;
    if (expQ.size() != 0) fail("read answer missing");
    finish_test;
  end
endmodule
bind msw_register_bank msw_checker #(.DUAL(DUAL)) chk (.clk(clk),
  .resetn(resetn), .ce(ce), .cmdValid(cmdValid), .cmdFrame(cmdFrame),
  .rdValid(rdValid), .rdData(rdData), .switchOn(switchOn),
  .generalOutputOne(generalOutputOne), .generalOutputTwo(generalOutputTwo),
  .generalOutputThree(generalOutputThree),
  .generalOutputFour(generalOutputFour),
  .sequencerActive(sequencerActive), .daisyActive(daisyActive));
